// file: common/switch_defs.vh
`ifndef SWITCH_DEFS_VH
`define SWITCH_DEFS_VH

// Port counts and widths
`define SW_NUM_MASTERS 3
`define SW_NUM_SLAVES 4
`define SW_ADDR_W 32
`define SW_DATA_W 64
`define SW_PRIO_W 2

// Master identifiers
`define SW_M_IFETCH 2'd0
`define SW_M_LDST 2'd1
`define SW_M_DMA 2'd2

// Slave decode: address bits [31:30]
`define SW_DEC_HI 31
`define SW_DEC_LO 30
`define SW_S_FLASH 2'd0
`define SW_S_CAL 2'd1
`define SW_S_SRAM 2'd2
`define SW_S_BRIDGE 2'd3

// Arbiter reset value of last granted master
`define SW_LAST_RST 2'd2

`endif

// file: design/slave_port_arbiter.v
`timescale 1ns/10ps
`include "switch_defs.vh"

module slave_port_arbiter #(
  parameter PRIO_W = `SW_PRIO_W
) (
  clk_sys,
  rstn,
  req,
  done,
  prio_0,
  prio_1,
  prio_2,
  owner_valid,
  owner
);
  input wire clk_sys;
  input wire rstn;
  input wire [2:0] req;
  input wire done;
  input wire [PRIO_W-1:0] prio_0;
  input wire [PRIO_W-1:0] prio_1;
  input wire [PRIO_W-1:0] prio_2;
  output reg owner_valid;
  output reg [1:0] owner;

  reg [1:0] last_q;
  reg [1:0] pick;
  reg found;
  reg [PRIO_W-1:0] best;
  reg [PRIO_W-1:0] pv;
  reg [1:0] cand;
  reg [2:0] sum;
  integer k;

  // Highest priority, ties broken round robin after last grant
  always @* begin
    pick = 2'd0;
    found = 1'b0;
    best = {PRIO_W{1'b0}};
    pv = {PRIO_W{1'b0}};
    cand = 2'd0;
    sum = 3'd0;
    for (k = 1; k <= 3; k = k + 1) begin
      sum = {1'b0, last_q} + k[2:0];
      if (sum >= 3'd3)
        sum = sum - 3'd3;
      cand = sum[1:0];
      pv = (cand == 2'd0) ? prio_0 : (cand == 2'd1) ? prio_1 : prio_2;
      if (req[cand] && (!found || pv > best)) begin // [RULE_05] [RULE_07]
        found = 1'b1;
        best = pv;
        pick = cand;
      end
    end
  end

  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      owner_valid <= 1'b0;
      owner <= 2'd0;
      last_q <= `SW_LAST_RST;
    end else if (owner_valid) begin
      if (done) begin
        owner_valid <= 1'b0; // [RULE_08]
      end
    end else if (found) begin
      owner_valid <= 1'b1;
      owner <= pick;
      last_q <= pick; // [RULE_07]
    end
  end
endmodule

// file: design/master_slave_switch.v
// Summary of operation
// [RULE_01] Three master ports: instruction fetch, load/store, DMA.
// [RULE_02] Four slave ports: flash, calibration bus, SRAM, peripheral bridge.
// [RULE_03] Each port has 32-bit address and 64-bit data paths.
// [RULE_04] Masters addressing different slaves transfer concurrently.
// [RULE_05] Contending masters: higher priority master wins the slave port.
// [RULE_06] Losing masters wait, no transfer, until the owner finishes.
// [RULE_07] Equal priority ties granted round robin after last granted master.
// [RULE_08] Priorities are inputs; a grant holds for the whole transaction.
`timescale 1ns/10ps
`include "switch_defs.vh"

module master_slave_switch #(
  parameter AW = `SW_ADDR_W,
  parameter DW = `SW_DATA_W,
  parameter PW = `SW_PRIO_W
) (
  clk_sys,
  rstn,
  m_req,
  m_last,
  m_write,
  m_addr,
  m_wdata,
  m_prio,
  m_ack,
  m_rdata,
  s_req,
  s_last,
  s_write,
  s_addr,
  s_wdata,
  s_ack,
  s_rdata
);
  input wire clk_sys;
  input wire rstn;
  input wire [2:0] m_req;
  input wire [2:0] m_last;
  input wire [2:0] m_write;
  input wire [3*AW-1:0] m_addr;
  input wire [3*DW-1:0] m_wdata;
  input wire [3*PW-1:0] m_prio;
  output reg [2:0] m_ack;
  output reg [3*DW-1:0] m_rdata;
  output reg [3:0] s_req;
  output reg [3:0] s_last;
  output reg [3:0] s_write;
  output reg [4*AW-1:0] s_addr;
  output reg [4*DW-1:0] s_wdata;
  input wire [3:0] s_ack;
  input wire [4*DW-1:0] s_rdata;

  wire [3:0] own_v;
  wire [7:0] own_id;
  reg [11:0] req_map;
  reg [3:0] fin;
  reg [3:0] s_req_d;
  reg [3:0] s_last_d;
  reg [3:0] s_write_d;
  reg [4*AW-1:0] s_addr_d;
  reg [4*DW-1:0] s_wdata_d;
  reg [2:0] m_ack_d;
  reg [3*DW-1:0] m_rdata_d;
  reg [1:0] sel;
  reg [1:0] o;
  reg rstn_meta_q;
  reg rstn_sync_q;
  reg [2:0] m_req_live;
  reg [11:0] grant_map;
  reg [2:0] held;
  integer i;
  integer j;
  integer t;
  integer v;
  integer w;
  integer x;

  // Reset asserts at once, releases two edges later
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstn_meta_q <= 1'b0;
      rstn_sync_q <= 1'b0;
    end else begin
      rstn_meta_q <= 1'b1;
      rstn_sync_q <= rstn_meta_q;
    end
  end

  // Request ignored while its ack stands, so no beat repeats
  always @* begin
    m_req_live = m_req & ~m_ack; // [RULE_06]
  end

  // Slave port owned by each master
  always @* begin
    grant_map = 12'h000;
    held = 3'h0;
    for (v = 0; v < 4; v = v + 1) begin
      if (own_v[v]) begin
        grant_map[own_id[v*2 +: 2]*4+v] = 1'b1;
        held[own_id[v*2 +: 2]] = 1'b1;
      end
    end
  end

  // Decode each master's target slave
  always @* begin
    req_map = 12'h000;
    sel = 2'd0;
    for (i = 0; i < 3; i = i + 1) begin
      sel = m_addr[i*AW+`SW_DEC_HI -: 2];
      if (m_req_live[i] && !held[i])
        req_map[sel*3+i] = 1'b1; // [RULE_01] [RULE_02]
    end
  end

  // Owner finishes on the last beat it is acked for
  always @* begin
    fin = 4'h0;
    for (t = 0; t < 4; t = t + 1)
      fin[t] = own_v[t] & s_req[t] & s_ack[t] & s_last[t]; // [RULE_08]
  end

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : arb
      slave_port_arbiter #(.PRIO_W(PW)) u_arb (
        .clk_sys(clk_sys),
        .rstn(rstn_sync_q),
        .req(req_map[g*3 +: 3]),
        .done(fin[g]),
        .prio_0(m_prio[0*PW +: PW]),
        .prio_1(m_prio[1*PW +: PW]),
        .prio_2(m_prio[2*PW +: PW]),
        .owner_valid(own_v[g]),
        .owner(own_id[g*2 +: 2])
      );
    end
  endgenerate

  // Route owner to each slave; non-owners see no ack and stall
  always @* begin
    s_req_d = 4'h0;
    s_last_d = 4'h0;
    s_write_d = 4'h0;
    s_addr_d = {4*AW{1'b0}};
    s_wdata_d = {4*DW{1'b0}};
    o = 2'd0;
    for (j = 0; j < 4; j = j + 1) begin
      o = own_id[j*2 +: 2];
      if (own_v[j] && !fin[j]) begin // [RULE_04] [RULE_06]
        s_req_d[j] = m_req_live[o] &
          (m_addr[o*AW+`SW_DEC_HI -: 2] == j[1:0]);
        s_last_d[j] = m_last[o];
        s_write_d[j] = m_write[o];
        s_addr_d[j*AW +: AW] = m_addr[o*AW +: AW]; // [RULE_03]
        s_wdata_d[j*DW +: DW] = m_wdata[o*DW +: DW];
      end
    end
  end

  // Return ack and read data from the owned slave to its master
  always @* begin
    m_ack_d = 3'h0;
    m_rdata_d = {3*DW{1'b0}};
    for (w = 0; w < 3; w = w + 1) begin
      for (x = 0; x < 4; x = x + 1) begin
        if (grant_map[w*4+x] && s_ack[x] && s_req[x]) begin
          m_ack_d[w] = 1'b1;
          m_rdata_d[w*DW +: DW] = s_rdata[x*DW +: DW];
        end
      end
    end
  end

  always @(posedge clk_sys or negedge rstn_sync_q) begin
    if (!rstn_sync_q) begin
      s_req <= 4'h0;
      s_last <= 4'h0;
      s_write <= 4'h0;
      s_addr <= {4*AW{1'b0}};
      s_wdata <= {4*DW{1'b0}};
      m_ack <= 3'h0;
      m_rdata <= {3*DW{1'b0}};
    end else begin
      s_req <= s_req_d & ~(s_ack & s_req); // [RULE_08]
      s_last <= s_last_d;
      s_write <= s_write_d;
      s_addr <= s_addr_d;
      s_wdata <= s_wdata_d;
      m_ack <= m_ack_d;
      m_rdata <= m_rdata_d;
    end
  end
endmodule

// file: verif/switch_properties.sv
`timescale 1ns/10ps
module switch_properties(
  input wire clk_sys,
  input wire rstn,
  input wire [2:0] m_req,
  input wire [2:0] m_ack,
  input wire [3:0] s_req,
  input wire [3:0] s_ack,
  input wire [127:0] s_addr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_ack_cause: assert property
    (|m_ack |-> ($past(s_ack) & $past(s_req)) != 4'h0) else $error("ack");
  a_ack_pulse: assert property
    (m_ack[0] |=> !m_ack[0]) else $error("pulse");
  a_beat_hold: assert property
    (s_req[0] && !s_ack[0] |=> s_req[0]) else $error("hold");
  a_addr_stable: assert property
    (s_req[2] && !s_ack[2] |=> $stable(s_addr[95:64])) else $error("addr");
  a_beat_end: assert property
    (s_req[1] && s_ack[1] |=> !s_req[1]) else $error("end");
  a_grant_delay: assert property
    ($rose(s_req[3]) |-> $past(m_req, 2) != 3'h0) else $error("early");
  a_route_cal: assert property
    (s_req[1] |-> s_addr[63:62] == 2'h1) else $error("cal");
  a_route_bridge: assert property
    (s_req[3] |-> s_addr[127:126] == 2'h3) else $error("bridge");
  cover property (&s_req[2:0]);
  cover property (s_req[2] && !s_ack[2]);
  cover property (m_ack[1]);
endmodule

// file: verif/slave_model.sv
`timescale 1ns/10ps
module slave_model(
  input wire clk_sys,
  input wire [3:0] s_req,
  input wire [127:0] s_addr,
  output logic [3:0] s_ack,
  output logic [255:0] s_rdata
);
  logic [7:0] r_q = 8'h5b;
  always @(posedge clk_sys) r_q <= {r_q[6:0], ^(r_q & 8'hb8)};
  always_comb begin
    for (int j = 0; j < 4; j++) begin
      s_ack[j] = s_req[j] & (r_q[j] | r_q[j+4]);
      s_rdata[j*64+:64] = {8{r_q}};
      if (s_ack[j]) s_rdata[j*64+:64] = {~s_addr[j*32+:32], s_addr[j*32+:32]};
    end
  end
endmodule

// file: verif/master_slave_switch_tb_top.sv
`timescale 1ns/10ps
module master_slave_switch_tb_top;
  logic clk_sys = 0, rstn = 0;
  logic [2:0] m_req = '0, m_last = 3'h7, m_write = '0, m_ack;
  logic [95:0] m_addr = '0;
  logic [191:0] m_wdata = '0, m_rdata;
  logic [5:0] m_prio = '0;
  logic [3:0] s_req, s_last, s_write, s_ack;
  logic [127:0] s_addr;
  logic [255:0] s_wdata, s_rdata;
  logic [31:0] x = 32'hdfc20e77;
  int bad_count, comparisons, cyc, lst[4] = '{2, 2, 2, 2}, q[$];
  always #50 clk_sys = ~clk_sys;
  master_slave_switch u_dut(.*);
  slave_model u_slv(.*);
  function logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(logic [63:0] g, e);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %h %h", $time, g, e);
    end
  endtask
  task print_verdict();
    $display("%0d of %0d bad", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk_sys) if (++cyc > 9999) begin
    bad_count++;
    print_verdict();
  end
  task automatic xfer(int i, logic [1:0] s, bit solo);
    logic [31:0] a = rnd();
    logic [63:0] d = {rnd(), rnd()};
    int n = 0, f = 0, h = 0;
    a[31:30] = s;
    a[1:0] = 2'(i);
    m_addr[i*32+:32] <= a;
    m_wdata[i*64+:64] <= d;
    m_write[i] <= a[2];
    m_req[i] <= 1'b1;
    do begin
      @(negedge clk_sys);
      n++;
      if (s_req[s] && f == 0) f = n;
      if (s_req[s] && s_ack[s] && s_addr[s*32+:32] == a) begin
        h++;
        chk(s_wdata[s*64+:64], d);
        chk({s_write[s], s_last[s]}, {a[2], 1'b1});
      end
    end while (m_ack[i] !== 1'b1 && n < 99);
    chk(m_ack[i], 1);
    chk(m_rdata[i*64+:64], {~a, a});
    chk(h, 1);
    if (solo) chk(f, 3);
    @(posedge clk_sys);
    m_req[i] <= 1'b0;
    q.push_back(i);
  endtask
  task automatic run(logic [2:0] m, logic [1:0] s, bit sp, logic [5:0] pr);
    int w, p;
    @(posedge clk_sys);
    m_prio <= pr;
    fork
      if (m[0]) xfer(0, s, sp);
      if (m[1]) xfer(1, s + 2'(sp), sp);
      if (m[2]) xfer(2, s + 2'(2 * sp), sp);
    join
    for (int i = 0; i < 3; i++) if (sp && m[i]) lst[(s + i) % 4] = i;
    if (sp) m = 3'h0;
    while (m != 3'h0) begin
      w = -1;
      for (int k = 1; k < 4; k++) begin
        p = (lst[s] + k) % 3;
        if (m[p] && (w < 0 || pr[p*2+:2] > pr[w*2+:2])) w = p;
      end
      chk(q.pop_front(), w);
      m[w] = 1'b0;
      lst[s] = w;
    end
    q.delete();
  endtask
  initial begin
    logic [31:0] r;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    run(3'h7, 2'h2, 1'b0, 6'h0);
    for (int k = 0; k < 99; k++) begin
      r = rnd();
      run(r[2:0] == 3'h0 ? 3'h6 : r[2:0], r[4:3], r[5], r[11:6]);
      $display("test %0d done", k);
    end
    print_verdict();
  end
endmodule
bind master_slave_switch switch_properties u_chk(.clk_sys, .rstn, .m_req,
  .m_ack, .s_req, .s_ack, .s_addr);
